// >>> cpu_lowpower_and_arith_decode.v
`include "cpu_lowpower_and_arith_decode_regs.vh"

module cpu_lowpower_and_arith_decode #(
    parameter STAB_CYCLES = `STAB_CYCLES
) (
    input  wire        clk_i,
    input  wire        reset_i,
    input  wire [7:0]  mem_rdata_i,
    input  wire        irq_i,
    input  wire        int_i,
    output wire [15:0] mem_addr_o,
    output wire        mem_rd_o,
    output wire        mem_wr_o,
    output wire [7:0]  mem_wdata_o,
    output wire        core_clk_en_o,
    output wire        standby_o,
    output wire [15:0] pc_o,
    output wire [15:0] sp_o,
    output wire [15:0] hx_o,
    output wire [7:0]  acc_o,
    output wire [7:0]  ccr_o
);

    localparam [6:0] S_FETCH   = 7'h01;
    localparam [6:0] S_OPER    = 7'h02;
    localparam [6:0] S_BRANCH  = 7'h04;
    localparam [6:0] S_STACK   = 7'h08;
    localparam [6:0] S_VECT    = 7'h10;
    localparam [6:0] S_STANDBY = 7'h20;
    localparam [6:0] S_STAB    = 7'h40;

    // Counter is 16 bits wide; the load value is cut to that width on purpose
    localparam [31:0] STAB_WIDE = STAB_CYCLES - 1;
    localparam [15:0] STAB_LOAD = STAB_WIDE[15:0];

    reg [6:0]  state_ff;
    reg [15:0] addr_ff;
    reg        rd_ff;
    reg        wr_ff;
    reg [7:0]  wdata_ff;
    reg        clk_en_ff;
    reg        standby_ff;
    reg        stop_ff;
    reg [15:0] pc_ff;
    reg [15:0] sp_ff;
    reg [15:0] hx_ff;
    reg [7:0]  acc_ff;
    reg [7:0]  ccr_ff;
    reg [7:0]  op_ff;
    reg [7:0]  rel_ff;
    reg [2:0]  cnt_ff;
    reg [15:0] stab_ff;

    reg [8:0]  sum;
    reg [7:0]  and_res;
    reg        half;
    reg        ovf;
    wire [15:0] sext = {{8{mem_rdata_i[7]}}, mem_rdata_i};
    wire [15:0] rel16 = {{8{rel_ff[7]}}, rel_ff};
    wire        int_req = irq_i | int_i;

    // [RULE13] Sum and flags
    always @*
    begin
        sum = {1'b0, acc_ff} + {1'b0, mem_rdata_i};
        if (op_ff == `OP_ADC_IMM)
        begin
            sum = sum + {8'h00, ccr_ff[`CCR_C]};
        end
        and_res = acc_ff & mem_rdata_i;
        half = (acc_ff[3] & mem_rdata_i[3]) | (mem_rdata_i[3] & ~sum[3])
             | (~sum[3] & acc_ff[3]);
        ovf = (acc_ff[7] & mem_rdata_i[7] & ~sum[7])
            | (~acc_ff[7] & ~mem_rdata_i[7] & sum[7]);
    end

    function [7:0] stack_byte;
        input [2:0] idx;
        begin
            case (idx)
                3'h0:    stack_byte = pc_ff[7:0];
                3'h1:    stack_byte = pc_ff[15:8];
                3'h2:    stack_byte = hx_ff[7:0];
                3'h3:    stack_byte = acc_ff;
                default: stack_byte = ccr_ff;
            endcase
        end
    endfunction

    // Shared entry into interrupt stacking; the mask is still as it was
    task start_stack;
        begin
            state_ff  <= S_STACK;
            addr_ff   <= sp_ff;
            rd_ff     <= 1'b0;
            wr_ff     <= 1'b1;
            wdata_ff  <= pc_ff[7:0];
            cnt_ff    <= 3'h0;
            clk_en_ff <= 1'b1;
            standby_ff <= 1'b0;
        end
    endtask

    always @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_ff  <= S_VECT;
            addr_ff   <= `VEC_RESET;
            rd_ff     <= 1'b1;
            wr_ff     <= 1'b0;
            wdata_ff  <= 8'h00;
            clk_en_ff <= 1'b1;
            standby_ff <= 1'b0;
            stop_ff   <= 1'b0;
            pc_ff     <= 16'h0000;
            sp_ff     <= `SP_RESET;
            hx_ff     <= 16'h0000;
            acc_ff    <= 8'h00;
            // [RULE4] Reset sets mask
            ccr_ff    <= `CCR_RESET;
            op_ff     <= 8'h00;
            rel_ff    <= 8'h00;
            cnt_ff    <= 3'h0;
            stab_ff   <= 16'h0000;
        end
        else
        begin
            case (state_ff)
                S_FETCH:
                begin
                    if (!ccr_ff[`CCR_I] && int_req)
                    begin
                        start_stack;
                    end
                    else
                    begin
                        op_ff   <= mem_rdata_i;
                        pc_ff   <= pc_ff + 16'h0001;
                        addr_ff <= pc_ff + 16'h0001;
                        case (mem_rdata_i)
                            `OP_ADD_SP, `OP_ADD_HX, `OP_BR_CC, `OP_BR_CS,
                            `OP_ADC_IMM, `OP_ADD_IMM, `OP_AND_IMM:
                            begin
                                state_ff <= S_OPER;
                            end
                            // [RULE1] Enter standby
                            `OP_WAIT, `OP_STOP:
                            begin
                                // [RULE2] [RULE3] Clear mask
                                ccr_ff[`CCR_I] <= 1'b0;
                                // [RULE5] Gate core clock
                                clk_en_ff <= 1'b0;
                                standby_ff <= 1'b1;
                                rd_ff     <= 1'b0;
                                stop_ff   <= (mem_rdata_i == `OP_STOP);
                                state_ff  <= S_STANDBY;
                            end
                            default:
                            begin
                                state_ff <= S_FETCH;
                            end
                        endcase
                    end
                end
                S_OPER:
                begin
                    pc_ff    <= pc_ff + 16'h0001;
                    addr_ff  <= pc_ff + 16'h0001;
                    state_ff <= S_FETCH;
                    case (op_ff)
                        // [RULE7] Signed add to stack pointer
                        `OP_ADD_SP: sp_ff <= sp_ff + sext;
                        // [RULE8] Signed add to index pair
                        `OP_ADD_HX: hx_ff <= hx_ff + sext;
                        `OP_BR_CC, `OP_BR_CS:
                        begin
                            rel_ff   <= mem_rdata_i;
                            rd_ff    <= 1'b0;
                            state_ff <= S_BRANCH;
                        end
                        // [RULE14] AND result
                        `OP_AND_IMM:
                        begin
                            acc_ff         <= and_res;
                            ccr_ff[`CCR_V] <= 1'b0;
                            ccr_ff[`CCR_N] <= and_res[7];
                            ccr_ff[`CCR_Z] <= (and_res == 8'h00);
                        end
                        // [RULE13] Add result
                        default:
                        begin
                            acc_ff         <= sum[7:0];
                            ccr_ff[`CCR_V] <= ovf;
                            ccr_ff[`CCR_H] <= half;
                            ccr_ff[`CCR_N] <= sum[7];
                            ccr_ff[`CCR_Z] <= (sum[7:0] == 8'h00);
                            // [RULE12] Carry out of bit 7
                            ccr_ff[`CCR_C] <= sum[8];
                        end
                    endcase
                end
                S_BRANCH:
                begin
                    rd_ff    <= 1'b1;
                    state_ff <= S_FETCH;
                    // [RULE9] [RULE10] Carry branch
                    if (ccr_ff[`CCR_C] == (op_ff == `OP_BR_CS))
                    begin
                        pc_ff   <= pc_ff + rel16;
                        addr_ff <= pc_ff + rel16;
                    end
                end
                S_STACK:
                begin
                    sp_ff  <= sp_ff - 16'h0001;
                    cnt_ff <= cnt_ff + 3'h1;
                    if (cnt_ff == `STACK_BYTES)
                    begin
                        // [RULE11] Mask after stacking
                        ccr_ff[`CCR_I] <= 1'b1;
                        wr_ff    <= 1'b0;
                        rd_ff    <= 1'b1;
                        addr_ff  <= `VEC_IRQ;
                        cnt_ff   <= 3'h0;
                        state_ff <= S_VECT;
                    end
                    else
                    begin
                        addr_ff  <= sp_ff - 16'h0001;
                        wdata_ff <= stack_byte(cnt_ff + 3'h1);
                    end
                end
                S_VECT:
                begin
                    if (cnt_ff == 3'h0)
                    begin
                        pc_ff[15:8] <= mem_rdata_i;
                        addr_ff     <= addr_ff + 16'h0001;
                        cnt_ff      <= 3'h1;
                    end
                    else
                    begin
                        pc_ff[7:0] <= mem_rdata_i;
                        addr_ff    <= {pc_ff[15:8], mem_rdata_i};
                        cnt_ff     <= 3'h0;
                        state_ff   <= S_FETCH;
                    end
                end
                S_STANDBY:
                begin
                    // Stop listens only to the external line
                    if (stop_ff && irq_i)
                    begin
                        stab_ff  <= STAB_LOAD;
                        state_ff <= S_STAB;
                    end
                    else if (!stop_ff && int_req)
                    begin
                        start_stack;
                    end
                end
                S_STAB:
                begin
                    // [RULE6] Oscillator settle delay
                    if (stab_ff == 16'h0000)
                    begin
                        start_stack;
                    end
                    else
                    begin
                        stab_ff <= stab_ff - 16'h0001;
                    end
                end
                default:
                begin
                    state_ff <= S_FETCH;
                end
            endcase
        end
    end

    assign mem_addr_o    = addr_ff;
    assign mem_rd_o      = rd_ff;
    assign mem_wr_o      = wr_ff;
    assign mem_wdata_o   = wdata_ff;
    assign core_clk_en_o = clk_en_ff;
    assign standby_o     = standby_ff;
    assign pc_o          = pc_ff;
    assign sp_o          = sp_ff;
    assign hx_o          = hx_ff;
    assign acc_o         = acc_ff;
    assign ccr_o         = ccr_ff;

endmodule // cpu_lowpower_and_arith_decode

// >>> cpu_lowpower_and_arith_decode_regs.vh
// Behaviour
// [RULE1] Two standby instructions, wait and stop, enter a low-power standby state.
// [RULE2] Wait clears the interrupt mask; it stays clear after an interrupt wake.
// [RULE3] Stop clears the interrupt mask; it stays clear after an external wake.
// [RULE4] A reset ending either standby leaves the interrupt mask set.
// [RULE5] Both standby instructions gate off the core clock while in standby.
// [RULE6] Leaving stop, the clock restarts only after the oscillator stabilization delay.
// [RULE7] Opcode A7 adds the sign-extended immediate to the stack pointer, flags kept, 2 cycles.
// [RULE8] Opcode AF adds the sign-extended immediate to the index pair, flags kept, 2 cycles.
// [RULE9] Opcode 24 branches to PC+2+offset when carry is clear, 3 cycles.
// [RULE10] Opcode 25 branches to PC+2+offset when carry is set, 3 cycles.
// [RULE11] A taken interrupt sets the mask after stacking and before the vector fetch.
// [RULE12] Carry is set by carry out of bit 7 on add; branches test it.
// [RULE13] Add and add-with-carry put the sum in A and update V, H, N, Z, C.
// [RULE14] AND stores into A, clears V, updates N and Z, keeps H and C.
`ifndef CPU_LOWPOWER_AND_ARITH_DECODE_REGS_VH
`define CPU_LOWPOWER_AND_ARITH_DECODE_REGS_VH

`define OP_ADD_SP    8'hA7
`define OP_ADD_HX    8'hAF
`define OP_BR_CC     8'h24
`define OP_BR_CS     8'h25
`define OP_ADC_IMM   8'hA9
`define OP_ADD_IMM   8'hAB
`define OP_AND_IMM   8'hA4
`define OP_STOP      8'h8E
`define OP_WAIT      8'h8F

`define CCR_C        0
`define CCR_Z        1
`define CCR_N        2
`define CCR_I        3
`define CCR_H        4
`define CCR_V        7
`define CCR_RESET    8'h68

`define SP_RESET     16'h00FF
`define VEC_RESET    16'hFFFE
`define VEC_IRQ      16'hFFFA
`define STACK_BYTES  3'h4

`define STAB_CYCLES  4096

`endif

// >>> cpu_lowpower_and_arith_decode_asserts.sv
module lowpower_decode_checker #(
    parameter int STAB_CYCLES = 8
) (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        irq_i,
    input wire logic [15:0] mem_addr_o,
    input wire logic        mem_rd_o,
    input wire logic        mem_wr_o,
    input wire logic        core_clk_en_o,
    input wire logic        standby_o,
    input wire logic [7:0]  ccr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WAKE_MAX = STAB_CYCLES + 3;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    property p_gated; standby_o == !core_clk_en_o; endproperty
    a_gated: assert property (p_gated) else $error("clock enable not inverse of standby");
    property p_quiet; standby_o |-> !mem_rd_o && !mem_wr_o; endproperty
    a_quiet: assert property (p_quiet) else $error("bus active in standby");
    property p_mask; standby_o |-> !ccr_o[3]; endproperty
    a_mask: assert property (p_mask) else $error("mask set in standby");
    property p_rst; $fell(reset_i) |-> ccr_o == 8'h68; endproperty
    a_rst: assert property (p_rst) else $error("mask not set by reset");
    property p_vec; $fell(mem_wr_o) |-> ccr_o[3] && mem_rd_o && mem_addr_o == 16'hFFFA; endproperty
    a_vec: assert property (p_vec) else $error("vector fetch not after stacking");
    property p_five; $rose(mem_wr_o) |-> mem_wr_o [*5] ##1 !mem_wr_o; endproperty
    a_five: assert property (p_five) else $error("stacking not five bytes");
    property p_wake; $fell(standby_o) |-> mem_wr_o && !ccr_o[3]; endproperty
    a_wake: assert property (p_wake) else $error("wake not followed by stacking");
    property p_irq; standby_o && irq_i |-> ##[1:WAKE_MAX] !standby_o; endproperty
    a_irq: assert property (p_irq) else $error("external wake too slow");

    c_wake: cover property ($fell(standby_o));
    c_stack: cover property ($rose(mem_wr_o));
    c_irq: cover property (standby_o && irq_i);
endmodule // lowpower_decode_checker

bind cpu_lowpower_and_arith_decode lowpower_decode_checker #(
    .STAB_CYCLES(STAB_CYCLES)
) i_lowpower_decode_checker (
    .clk_i(clk_i), .reset_i(reset_i), .irq_i(irq_i), .mem_addr_o(mem_addr_o),
    .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .core_clk_en_o(core_clk_en_o),
    .standby_o(standby_o), .ccr_o(ccr_o)
);

// >>> bus_memory_model.sv
module bus_memory_model (
    input  wire logic        clk_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic [7:0]  wdata_i,
    output logic      [7:0]  rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] m [int];
    logic [7:0] last_ff;
    // Unloaded bytes read as a no-op; idle bus shows the inverse of the last byte
    always @*
        rdata_o = rd_i ? (m.exists(addr_i) ? m[addr_i] : 8'h9D) : ~last_ff;
    always @(posedge clk_i)
    begin
        if (wr_i)
            m[addr_i] = wdata_i;
        last_ff <= rdata_o;
    end
endmodule // bus_memory_model

// >>> cpu_lowpower_and_arith_decode_tb.sv
module cpu_lowpower_and_arith_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STAB = 8;
    logic        clk_i = 0, reset_i = 1, irq_i = 0, int_i = 0;
    logic [7:0]  mem_rdata_i, mem_wdata_o, acc_o, ccr_o;
    logic [15:0] mem_addr_o, pc_o, sp_o, hx_o;
    logic        mem_rd_o, mem_wr_o, core_clk_en_o, standby_o;
    int          bad_count = 0, check_count = 0;

    cpu_lowpower_and_arith_decode #(.STAB_CYCLES(STAB)) i_cpu_lowpower_and_arith_decode (
        .clk_i(clk_i), .reset_i(reset_i), .mem_rdata_i(mem_rdata_i), .irq_i(irq_i),
        .int_i(int_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
        .mem_wdata_o(mem_wdata_o), .core_clk_en_o(core_clk_en_o), .standby_o(standby_o),
        .pc_o(pc_o), .sp_o(sp_o), .hx_o(hx_o), .acc_o(acc_o), .ccr_o(ccr_o));
    bus_memory_model i_bus_memory_model (.clk_i(clk_i), .addr_i(mem_addr_o),
        .rd_i(mem_rd_o), .wr_i(mem_wr_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));

    always #20 clk_i = ~clk_i;

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
            bad_count++;
        end
    endtask
    task automatic load(input logic [15:0] a, input logic [7:0] b[]);
        foreach (b[i]) i_bus_memory_model.m[a + i] = b[i];
    endtask
    // Bounded waits: a stuck core ends the run as a mismatch
    task automatic wait_fetch(input logic [15:0] a, output int n);
        n = 0;
        while (!(mem_rd_o === 1'b1 && mem_addr_o === a) && n < 60)
        begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 60)
        begin
            bad_count++;
            test_done();
        end
    endtask
    task automatic wait_standby(input logic lvl, output int n);
        n = 0;
        while (standby_o !== lvl && n < 60) begin @(negedge clk_i); n++; end
        if (n >= 60)
        begin
            bad_count++;
            test_done();
        end
    endtask
    task automatic step(input logic [15:0] a, nx, input int cyc, input logic [7:0] ax, cx);
        int n;
        wait_fetch(a, n);
        wait_fetch(nx, n);
        check("cycles", 16'(n), 16'(cyc));
        check("pc", pc_o, nx);
        check("acc", {8'h00, acc_o}, {8'h00, ax});
        check("flags", {8'h00, ccr_o}, {8'h00, cx});
    endtask

    task automatic arith_scenario();
        step(16'h0100, 16'h0102, 2, 8'h00, 8'h68);
        check("stack", sp_o, 16'h00FD);
        step(16'h0102, 16'h0104, 2, 8'h00, 8'h68);
        check("index", hx_o, 16'hFF80);
        step(16'h0104, 16'h0106, 2, 8'h80, 8'h6C);
        step(16'h0106, 16'h0108, 2, 8'h00, 8'hEB);
        step(16'h0108, 16'h010A, 2, 8'h00, 8'h6B);
    endtask
    task automatic branch_scenario();
        step(16'h010A, 16'h011C, 3, 8'h00, 8'h6B);
        step(16'h011C, 16'h011E, 3, 8'h00, 8'h6B);
        step(16'h011E, 16'h0120, 2, 8'h00, 8'h7B);
        step(16'h0120, 16'h0122, 2, 8'h00, 8'h6A);
        step(16'h0122, 16'h0124, 3, 8'h00, 8'h6A);
        step(16'h0124, 16'h0116, 3, 8'h00, 8'h6A);
    endtask
    task automatic wait_scenario();
        int n;
        wait_standby(1'b1, n);
        check("mask", {15'h0, ccr_o[3]}, 16'h0000);
        repeat (5) @(negedge clk_i);
        check("gated", {15'h0, core_clk_en_o}, 16'h0000);
        int_i = 1'b1;
        wait_fetch(16'h0200, n);
        int_i = 1'b0;
        check("stack", sp_o, 16'h00F8);
        check("stacked", {8'h00, i_bus_memory_model.m[16'h00F9]}, 16'h0062);
        check("mask", {15'h0, ccr_o[3]}, 16'h0001);
        check("running", {15'h0, core_clk_en_o}, 16'h0001);
    endtask
    task automatic stop_scenario();
        int n;
        wait_standby(1'b1, n);
        // Internal request must not end stop
        int_i = 1'b1;
        repeat (STAB + 4) @(negedge clk_i);
        check("stopped", {15'h0, standby_o}, 16'h0001);
        int_i = 1'b0;
        irq_i = 1'b1;
        wait_standby(1'b0, n);
        check("delay", {15'h0, n > STAB}, 16'h0001);
        wait_fetch(16'h0200, n);
        irq_i = 1'b0;
        check("stacked", {8'h00, i_bus_memory_model.m[16'h00F4]}, 16'h0062);
    endtask
    task automatic reset_scenario();
        int n;
        wait_standby(1'b1, n);
        reset_i = 1'b1;
        @(negedge clk_i);
        check("flags", {8'h00, ccr_o}, 16'h0068);
        reset_i = 1'b0;
        wait_fetch(16'h0100, n);
        check("flags", {8'h00, ccr_o}, 16'h0068);
    endtask

    initial
    begin
        load(16'hFFFA, {8'h02, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00});
        load(16'h0100, {8'hA7, 8'hFE, 8'hAF, 8'h80, 8'hAB, 8'h80, 8'hAB, 8'h80,
                        8'hA4, 8'h03, 8'h25, 8'h10});
        load(16'h011C, {8'h24, 8'h10, 8'hA9, 8'hFF, 8'hAB, 8'h00, 8'h25, 8'h10,
                        8'h24, 8'hF0});
        load(16'h0116, {8'h8F});
        load(16'h0200, {8'h8E});
        repeat (16) @(posedge clk_i);
        @(negedge clk_i);
        reset_i = 1'b0;
        arith_scenario();
        branch_scenario();
        wait_scenario();
        stop_scenario();
        reset_scenario();
        test_done();
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        test_done();
    end
endmodule // cpu_lowpower_and_arith_decode_tb
